//--- mq_fifo.sv
// Purpose: Multi-queue FIFO, shared write and read ports, flag busses.
// Assumes: Write and read ports run on ref_clk; config set before traffic.
// Notes: Operation
// Operation
// - One to thirty-two queues share one write and one read port.
// - Queues get whole blocks, zero to all, depth a block multiple.
// - Block pool is 128 blocks, or 256 in the larger variant.
// - Block is 512x18 unless both ports are x9, then 1024x9.
// - Write and read widths pick x9 or x18, each global per side.
// - Separate write and read queue selects; same queue allowed both sides.
// - One shared clock, one enable per port; data stored per edge while enabled.
// - Writer writes only while selected queue not full; full flag shows it.
// - Selected queue's next word falls into output register by itself.
// - Output valid only when output word is data of selected queue.
// - Switching to an empty queue keeps the previous word on output.
// - Per-queue almost-full threshold; flag follows write-selected queue.
// - Per-queue almost-empty threshold; flag follows read-selected queue.
// - Two 8-bit status busses report almost-full and almost-empty states.
// - Busses show eight queues per quadrant, bit order is queue order.
// - Four quadrants always cycle; unconfigured bits are don't care.
// - Polled mode advances each bus one quadrant per clock edge.
// - Polled or direct is one setting for both busses.
// - Direct mode: write side picks full-bus quadrant, read side empty-bus.
// - Expansion reaches 256 queues; a queue never spans devices.
// - Sync output high exactly while the polled empty bus shows quadrant one of this device.
// - Direct mode captures empty-bus quadrant from read select on strobe.
// - Token out pulses after fourth quadrant; next device shows first.
`timescale 1ns/1ps
`default_nettype none
module mq_fifo import mq_fifo_pkg::*; #(
   parameter int POOL_BLOCKS = POOL_SMALL,
   parameter bit CHAIN_HEAD = 1'b1
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [9:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire wr_port_t wr_port,
   input wire rd_port_t rd_port,
   input wire logic poll_token_in,
   output logic [DW-1:0] read_data,
   output logic output_valid_flag,
   output logic queue_full_flag,
   output logic almost_full_flag,
   output logic almost_empty_flag,
   output logic [QUAD_W-1:0] almost_full_status_bus,
   output logic [QUAD_W-1:0] almost_empty_status_bus,
   output logic almost_empty_bus_sync,
   output logic poll_token_out
);
   localparam int DEPTH = POOL_BLOCKS * BLOCK_WORDS;
   localparam int AW = $clog2(DEPTH);
   localparam int BSH = $clog2(BLOCK_WORDS);
   localparam logic [ALLOC_W-1:0] ALLOC_RST = ALLOC_W'(POOL_BLOCKS / QMAX);

   // ==========================================================
   // Configuration registers over Avalon-MM
   logic [QCNT_W-1:0] qcnt_q, qcnt_d;
   logic direct_q, direct_d, wrx9_q, wrx9_d, rdx9_q, rdx9_d;
   logic [ALLOC_W-1:0] alloc_q [QMAX];
   logic [ALLOC_W-1:0] alloc_d [QMAX];
   logic [AW:0] afth_q [QMAX];
   logic [AW:0] afth_d [QMAX];
   logic [AW:0] aeth_q [QMAX];
   logic [AW:0] aeth_d [QMAX];
   logic ack_q, ack_d, accept;
   logic [31:0] rdata_q, rdata_d, cur, merged;
   logic [4:0] slot;
   logic [QMAX-1:0] full_vec, af_vec, ae_vec;
   logic out_valid_q;
   flag_mode_t mode;

   assign accept = (avs_read || avs_write) && !ack_q;
   assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
   assign avs_readdata = rdata_q;
   assign slot = avs_address[6:2];
   assign mode = flag_mode_t'(direct_q);

   always_comb begin
      cur = '0;
      if (avs_address[9:2] == CTRL_OFS[9:2]) begin
         cur[QCNT_LSB +: QCNT_W] = qcnt_q;
         cur[DIRECT_BIT] = direct_q;
         cur[WRX9_BIT] = wrx9_q;
         cur[RDX9_BIT] = rdx9_q;
      end else if (avs_address[9:2] == STATUS_OFS[9:2]) begin
         cur[3:0] = {almost_empty_flag, out_valid_q, almost_full_flag, queue_full_flag};
      end else if (avs_address[9:7] == ALLOC_BASE[9:7]) begin
         cur[ALLOC_W-1:0] = alloc_q[slot];
      end else if (avs_address[9:7] == AFTH_BASE[9:7]) begin
         cur[AW:0] = afth_q[slot];
      end else if (avs_address[9:7] == AETH_BASE[9:7]) begin
         cur[AW:0] = aeth_q[slot];
      end
      for (int b = 0; b < 4; b++) begin
         merged[8*b +: 8] = avs_byteenable[b] ? avs_writedata[8*b +: 8] : cur[8*b +: 8];
      end
   end

   // Config is static: software loads it while the queues are idle.
   always_comb begin
      ack_d = accept;
      rdata_d = (accept && avs_read) ? cur : rdata_q;
      qcnt_d = qcnt_q;
      direct_d = direct_q;
      wrx9_d = wrx9_q;
      rdx9_d = rdx9_q;
      alloc_d = alloc_q;
      afth_d = afth_q;
      aeth_d = aeth_q;
      if (accept && avs_write) begin
         if (avs_address[9:2] == CTRL_OFS[9:2]) begin
            if (merged[QCNT_LSB +: QCNT_W] != '0 && merged[QCNT_LSB +: QCNT_W] <= QCNT_RST) begin
               qcnt_d = merged[QCNT_LSB +: QCNT_W];
            end
            direct_d = merged[DIRECT_BIT];
            wrx9_d = merged[WRX9_BIT];
            rdx9_d = merged[RDX9_BIT];
         end else if (avs_address[9:7] == ALLOC_BASE[9:7]) begin
            alloc_d[slot] = merged[ALLOC_W-1:0];
         end else if (avs_address[9:7] == AFTH_BASE[9:7]) begin
            afth_d[slot] = merged[AW:0];
         end else if (avs_address[9:7] == AETH_BASE[9:7]) begin
            aeth_d[slot] = merged[AW:0];
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         ack_q <= 1'b0;
         rdata_q <= '0;
         qcnt_q <= QCNT_RST;
         direct_q <= 1'b0;
         wrx9_q <= 1'b0;
         rdx9_q <= 1'b0;
         for (int i = 0; i < QMAX; i++) begin
            alloc_q[i] <= ALLOC_RST;
            afth_q[i] <= (AW+1)'(THR_RST);
            aeth_q[i] <= (AW+1)'(THR_RST);
         end
      end else begin
         ack_q <= ack_d;
         rdata_q <= rdata_d;
         qcnt_q <= qcnt_d;
         direct_q <= direct_d;
         wrx9_q <= wrx9_d;
         rdx9_q <= rdx9_d;
         alloc_q <= alloc_d;
         afth_q <= afth_d;
         aeth_q <= aeth_d;
      end
   end

   // ==========================================================
   // Queue regions and trackers
   logic [AW:0] size_w [QMAX];
   logic [AW:0] lvl_w [QMAX];
   logic [AW-1:0] base [QMAX];
   logic [AW-1:0] wr_off_w [QMAX];
   logic [AW-1:0] rd_off_w [QMAX];
   logic [AW-1:0] rd_next_w [QMAX];
   logic push, pop;

   // Both-x9 blocks of 1024x9 hold byte pairs, the same bits as 512x18.
   always_comb begin
      for (int i = 0; i < QMAX; i++) begin
         size_w[i] = (QCNT_W'(i) < qcnt_q) ? ((AW+1)'(alloc_q[i]) << BSH) : '0;
      end
      base[0] = '0;
      for (int i = 1; i < QMAX; i++) begin
         base[i] = base[i-1] + size_w[i-1][AW-1:0];
      end
   end

   for (genvar g = 0; g < QMAX; g++) begin : g_queue
      queue_level #(.AW(AW)) u_level (
         .ref_clk(ref_clk),
         .sys_rst(sys_rst),
         .size(size_w[g]),
         .af_thr(afth_q[g]),
         .ae_thr(aeth_q[g]),
         .push(push && (wr_port.qsel == QSEL_W'(g))),
         .pop(pop && (rd_port.qsel == QSEL_W'(g))),
         .wr_off(wr_off_w[g]),
         .rd_off(rd_off_w[g]),
         .rd_next(rd_next_w[g]),
         .level(lvl_w[g]),
         .full(full_vec[g]),
         .almost_full(af_vec[g]),
         .almost_empty(ae_vec[g])
      );
   end

   // ==========================================================
   // Write port
   logic [DW-1:0] mem [DEPTH];
   logic [HW-1:0] pack_q, pack_d;
   logic pend_q, pend_d;
   logic [QSEL_W-1:0] wsel_q;
   logic [DW-1:0] wword;
   logic [AW-1:0] waddr, raddr;

   assign queue_full_flag = full_vec[wr_port.qsel];
   assign almost_full_flag = af_vec[wr_port.qsel];
   assign waddr = base[wr_port.qsel] + wr_off_w[wr_port.qsel];

   // A pending x9 byte is dropped when the write select moves away.
   always_comb begin
      pack_d = pack_q;
      pend_d = pend_q && (wr_port.qsel == wsel_q);
      push = 1'b0;
      wword = wr_port.data;
      if (wr_port.en && !queue_full_flag) begin
         if (!wrx9_q) begin
            push = 1'b1;
         end else if (!pend_d) begin
            pack_d = wr_port.data[HW-1:0];
            pend_d = 1'b1;
         end else begin
            push = 1'b1;
            wword = {wr_port.data[HW-1:0], pack_q};
            pend_d = 1'b0;
         end
      end
   end

   // ==========================================================
   // Read port, first word fall through
   logic [QSEL_W-1:0] rsel_q;
   logic [DW-1:0] word_q;
   logic half_q, half_d, out_valid_d, same, consume, load;
   logic [AW:0] avail;

   assign same = (rd_port.qsel == rsel_q);
   assign consume = rd_port.en && out_valid_q && same;
   assign pop = consume && (!rdx9_q || half_q);
   assign avail = lvl_w[rd_port.qsel] - (AW+1)'(pop);
   assign load = (avail != '0) && (!out_valid_q || pop || !same);
   assign raddr = base[rd_port.qsel] + (pop ? rd_next_w[rd_port.qsel] : rd_off_w[rd_port.qsel]);
   assign almost_empty_flag = ae_vec[rd_port.qsel];
   assign output_valid_flag = out_valid_q;
   assign read_data = rdx9_q ? {{HW{1'b0}}, half_q ? word_q[DW-1:HW] : word_q[HW-1:0]} : word_q;

   always_comb begin
      half_d = (same && consume && rdx9_q) ? !half_q : (same && half_q);
      if (load) begin
         out_valid_d = 1'b1;
      end else if (pop || !same) begin
         out_valid_d = 1'b0;
      end else begin
         out_valid_d = out_valid_q;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[waddr] <= wword;
      end
      if (load) begin
         word_q <= mem[raddr];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         pack_q <= '0;
         pend_q <= 1'b0;
         wsel_q <= '0;
         rsel_q <= '0;
         half_q <= 1'b0;
         out_valid_q <= 1'b0;
      end else begin
         pack_q <= pack_d;
         pend_q <= pend_d;
         wsel_q <= wr_port.qsel;
         rsel_q <= rd_port.qsel;
         half_q <= half_d;
         out_valid_q <= out_valid_d;
      end
   end

   // ==========================================================
   // Flag status busses
   logic [1:0] afq_q, afq_d, aeq_q, aeq_d;
   logic [QUAD_W-1:0] afb_q, afb_d, aeb_q, aeb_d;
   logic act_q, act_d, sync_q, sync_d, tok_q, tok_d;

   always_comb begin
      afq_d = afq_q + 2'h1;
      aeq_d = aeq_q;
      act_d = act_q;
      sync_d = 1'b0;
      tok_d = 1'b0;
      afb_d = af_vec[QUAD_W*afq_q +: QUAD_W];
      aeb_d = '0;
      if (mode == MODE_DIRECT) begin
         afq_d = wr_port.bus_strobe ? wr_port.qsel[1:0] : afq_q;
         aeq_d = rd_port.bus_strobe ? rd_port.qsel[1:0] : aeq_q;
         aeb_d = ae_vec[QUAD_W*aeq_q +: QUAD_W];
      end else if (act_q) begin
         aeb_d = ae_vec[QUAD_W*aeq_q +: QUAD_W];
         sync_d = (aeq_q == 2'h0);
         tok_d = (aeq_q == 2'h3);
         act_d = (aeq_q != 2'h3);
         aeq_d = aeq_q + 2'h1;
      end else if (poll_token_in) begin
         aeb_d = ae_vec[QUAD_W-1:0];
         sync_d = 1'b1;
         act_d = 1'b1;
         aeq_d = 2'h1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         afq_q <= '0;
         aeq_q <= '0;
         afb_q <= '0;
         aeb_q <= '0;
         act_q <= CHAIN_HEAD;
         sync_q <= 1'b0;
         tok_q <= 1'b0;
      end else begin
         afq_q <= afq_d;
         aeq_q <= aeq_d;
         afb_q <= afb_d;
         aeb_q <= aeb_d;
         act_q <= act_d;
         sync_q <= sync_d;
         tok_q <= tok_d;
      end
   end

   assign almost_full_status_bus = afb_q;
   assign almost_empty_status_bus = aeb_q;
   assign almost_empty_bus_sync = sync_q;
   assign poll_token_out = tok_q;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   sequence s_fourth;
      mode == MODE_POLLED && act_q && aeq_q == 2'h3;
   endsequence
   sequence s_direct_pick;
      mode == MODE_DIRECT && rd_port.bus_strobe;
   endsequence

   a_push_not_full: assert property (push |-> !full_vec[wr_port.qsel])
      else $error("Push into a full queue.");
   a_valid_has_data: assert property ($rose(out_valid_q) |-> $past(load))
      else $error("Output valid rose without a load.");
   a_hold_on_empty: assert property (!same && avail == '0 |=> $stable(word_q) && !out_valid_q)
      else $error("Output word changed on switch to empty queue.");
   a_fall_through: assert property (!out_valid_q && same && avail != '0 |=> out_valid_q)
      else $error("Head word did not fall through.");
   a_poll_step: assert property (mode == MODE_POLLED ##1 mode == MODE_POLLED |-> afq_q == $past(afq_q) + 2'h1)
      else $error("Almost-full bus did not advance one quadrant.");
   a_sync_quad_one: assert property (mode == MODE_POLLED && act_q && aeq_q == 2'h0 |=> almost_empty_bus_sync)
      else $error("Sync missing on quadrant one.");
   a_token_pulse: assert property (s_fourth |=> poll_token_out ##1 !poll_token_out || poll_token_in)
      else $error("Token did not pulse after fourth quadrant.");
   a_direct_quad: assert property (s_direct_pick ##1 mode == MODE_DIRECT |-> aeq_q == $past(rd_port.qsel[1:0]))
      else $error("Direct quadrant not captured from read select.");
endmodule : mq_fifo
`default_nettype wire

//--- mq_fifo_pkg.sv
// Purpose: Shared constants and carriers for the multi-queue FIFO.
// Assumes: One clock drives both ports.
// Notes: Offsets are Avalon byte addresses.
package mq_fifo_pkg;
   // ==========================================================
   // Geometry
   localparam int QMAX = 32;
   localparam int QSEL_W = 5;
   localparam int DW = 18;
   localparam int HW = 9;
   localparam int BLOCK_WORDS = 512;
   localparam int POOL_SMALL = 128;
   localparam int POOL_LARGE = 256;
   localparam int QUAD_W = 8;
   localparam int ALLOC_W = 9;
   // ==========================================================
   // Register map and fields
   localparam logic [9:0] CTRL_OFS = 10'h000;
   localparam logic [9:0] STATUS_OFS = 10'h004;
   localparam logic [9:0] ALLOC_BASE = 10'h100;
   localparam logic [9:0] AFTH_BASE = 10'h200;
   localparam logic [9:0] AETH_BASE = 10'h300;
   localparam int QCNT_LSB = 0;
   localparam int QCNT_W = 6;
   localparam int DIRECT_BIT = 8;
   localparam int WRX9_BIT = 9;
   localparam int RDX9_BIT = 10;
   localparam logic [5:0] QCNT_RST = 6'h20;
   localparam int THR_RST = 8;
   // ==========================================================
   // Types
   typedef enum logic {
      MODE_POLLED = 1'b0,
      MODE_DIRECT = 1'b1
   } flag_mode_t;
   typedef struct packed {
      logic en;
      logic bus_strobe;
      logic [QSEL_W-1:0] qsel;
      logic [DW-1:0] data;
   } wr_port_t;
   typedef struct packed {
      logic en;
      logic bus_strobe;
      logic [QSEL_W-1:0] qsel;
   } rd_port_t;
endpackage : mq_fifo_pkg

//--- queue_level.sv
// Purpose: Pointers, fill level and flags of one queue.
// Assumes: Size is a whole number of blocks; zero disables the queue.
// Notes: Pointers are offsets inside the queue's own region.
`timescale 1ns/1ps
`default_nettype none
module queue_level import mq_fifo_pkg::*; #(
   parameter int AW = 16
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [AW:0] size,
   input wire logic [AW:0] af_thr,
   input wire logic [AW:0] ae_thr,
   input wire logic push,
   input wire logic pop,
   output logic [AW-1:0] wr_off,
   output logic [AW-1:0] rd_off,
   output logic [AW-1:0] rd_next,
   output logic [AW:0] level,
   output logic full,
   output logic almost_full,
   output logic almost_empty
);
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d, wr_next;
   logic [AW:0] lvl_q, lvl_d;

   function automatic logic [AW-1:0] step(input logic [AW-1:0] off, input logic [AW:0] sz);
      logic [AW:0] n;
      n = {1'b0, off} + {{AW{1'b0}}, 1'b1};
      step = (n >= sz) ? '0 : n[AW-1:0];
   endfunction : step

   always_comb begin
      wr_next = step(wr_q, size);
      rd_next = step(rd_q, size);
      wr_d = push ? wr_next : wr_q;
      rd_d = pop ? rd_next : rd_q;
      lvl_d = lvl_q;
      if (push && !pop) begin
         lvl_d = lvl_q + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
         lvl_d = lvl_q - {{AW{1'b0}}, 1'b1};
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         wr_q <= '0;
         rd_q <= '0;
         lvl_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         lvl_q <= lvl_d;
      end
   end

   assign wr_off = wr_q;
   assign rd_off = rd_q;
   assign level = lvl_q;
   assign full = (lvl_q >= size);
   assign almost_full = ((size - lvl_q) <= af_thr);
   assign almost_empty = (lvl_q <= ae_thr);
endmodule : queue_level
`default_nettype wire

//--- mq_host.sv
// Purpose: Write-side and read-side host logic that drives the queue ports.
// Assumes: Shares ref_clk with the FIFO; past the blocking idle levels at time zero, every change is a non-blocking assignment after an edge.
// Notes: The almost-empty bus token is looped back, as a single device needs.
`timescale 1ns/1ps
`default_nettype none
module mq_host import mq_fifo_pkg::*; (
   input wire logic ref_clk,
   input wire logic queue_full_flag,
   input wire logic poll_token_out,
   output var wr_port_t wr_port,
   output var rd_port_t rd_port,
   output logic poll_token_in
);
   // ==========================================================
   // Token loop and idle levels
   assign poll_token_in = poll_token_out;
   initial begin
      wr_port = '0;
      rd_port = '0;
   end
   // ==========================================================
   // Write side
   // A full queue is not written unless insist asks for a refused write.
   task automatic push(input logic [QSEL_W-1:0] q, input logic [DW-1:0] d, input bit insist);
      wr_port.qsel <= q;
      @(posedge ref_clk);
      if (!queue_full_flag || insist) begin
         wr_port.en <= 1'b1;
         wr_port.data <= d;
         @(posedge ref_clk);
         wr_port.en <= 1'b0;
      end
   endtask : push
   // ==========================================================
   // Read side and quadrant strobes
   task automatic rd_sel(input logic [QSEL_W-1:0] q);
      rd_port.qsel <= q;
      @(posedge ref_clk);
   endtask : rd_sel
   task automatic pop();
      rd_port.en <= 1'b1;
      @(posedge ref_clk);
      rd_port.en <= 1'b0;
   endtask : pop
   task automatic strobe(input logic [QSEL_W-1:0] q);
      wr_port.bus_strobe <= 1'b1;
      wr_port.qsel <= q;
      rd_port.bus_strobe <= 1'b1;
      rd_port.qsel <= q;
      @(posedge ref_clk);
      wr_port.bus_strobe <= 1'b0;
      rd_port.bus_strobe <= 1'b0;
   endtask : strobe
endmodule : mq_host
`default_nettype wire

//--- multi_queue_fifo_with_flag_busses_tb_top.sv
// Purpose: Self-checking bench for the multi-queue FIFO.
// Assumes: Default pool of 128 blocks, single device as chain head.
// Notes: Outputs are sampled at rising edges, before that edge's updates land.
`timescale 1ns/1ps
`default_nettype none
module multi_queue_fifo_with_flag_busses_tb_top import mq_fifo_pkg::*;;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [9:0] avs_address = '0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = '0;
   logic [3:0] avs_byteenable = 4'hf;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   wr_port_t wr_port;
   rd_port_t rd_port;
   logic poll_token_in, poll_token_out, output_valid_flag, queue_full_flag;
   logic almost_full_flag, almost_empty_flag, almost_empty_bus_sync;
   logic [DW-1:0] read_data;
   logic [QUAD_W-1:0] almost_full_status_bus, almost_empty_status_bus;
   int n_mismatch = 0;
   int samples_checked = 0;
   logic [31:0] d;
   int n80, nbad;

   always #4 ref_clk = ~ref_clk;

   mq_fifo i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .wr_port(wr_port), .rd_port(rd_port), .poll_token_in(poll_token_in),
      .read_data(read_data), .output_valid_flag(output_valid_flag),
      .queue_full_flag(queue_full_flag), .almost_full_flag(almost_full_flag),
      .almost_empty_flag(almost_empty_flag), .almost_full_status_bus(almost_full_status_bus),
      .almost_empty_status_bus(almost_empty_status_bus),
      .almost_empty_bus_sync(almost_empty_bus_sync), .poll_token_out(poll_token_out));

   mq_host i_host (.ref_clk(ref_clk), .queue_full_flag(queue_full_flag),
      .poll_token_out(poll_token_out), .wr_port(wr_port), .rd_port(rd_port),
      .poll_token_in(poll_token_in));

   // ==========================================================
   // Shared tasks
   task automatic tick();
      @(posedge ref_clk);
   endtask : tick
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
         n_mismatch++;
      end
   endtask : chk
   task automatic av_xfer(input logic [9:0] a, input logic wr, input logic [31:0] wd,
                          output logic [31:0] rd);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= wd;
      avs_read <= !wr;
      avs_write <= wr;
      do begin
         tick();
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      rd = avs_readdata;
      if (n >= 50) n_mismatch++;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      tick();
   endtask : av_xfer
   task automatic wait_valid();
      int n;
      n = 0;
      do begin
         tick();
         n++;
      end while (output_valid_flag !== 1'b1 && n < 8);
      if (n >= 8) n_mismatch++;
   endtask : wait_valid
   task automatic summarize();
      if (n_mismatch == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : summarize

   initial begin
      #400000;
      n_mismatch++;
      summarize();
   end

   // ==========================================================
   // Test sequence
   initial begin
      repeat (3) tick();
      sys_rst <= 1'b0;
      av_xfer(CTRL_OFS, 1'b0, '0, d);
      chk(d, 32'h0000_0020);
      av_xfer(AFTH_BASE + 10'h014, 1'b0, '0, d);
      chk(d, 32'h0000_0008);
      av_xfer(ALLOC_BASE, 1'b0, '0, d);
      chk(d, 32'h0000_0004);
      av_xfer(10'h0f0, 1'b0, '0, d);
      chk(d, 32'h0000_0000);
      // Fall-through, peek on reselect, hold on an empty queue.
      i_host.push(5'h03, 18'h1a5a5, 1'b0);
      i_host.push(5'h03, 18'h2c3c3, 1'b0);
      i_host.rd_sel(5'h03);
      wait_valid();
      chk(32'(read_data), 32'h1a5a5);
      chk(32'(almost_empty_flag), 32'h1);
      i_host.rd_sel(5'h05);
      repeat (3) tick();
      chk(32'(output_valid_flag), 32'h0);
      chk(32'(read_data), 32'h1a5a5);
      i_host.rd_sel(5'h03);
      wait_valid();
      chk(32'(read_data), 32'h1a5a5);
      i_host.pop();
      wait_valid();
      chk(32'(read_data), 32'h2c3c3);
      i_host.pop();
      repeat (2) tick();
      chk(32'(output_valid_flag), 32'h0);
      // One-block queue: almost-full boundary, full, refused write.
      av_xfer(ALLOC_BASE + 10'h01c, 1'b1, 32'h1, d);
      for (int i = 0; i < 503; i++) i_host.push(5'h07, 18'(i), 1'b0);
      tick();
      chk(32'(almost_full_flag), 32'h0);
      i_host.push(5'h07, 18'd503, 1'b0);
      tick();
      chk(32'(almost_full_flag), 32'h1);
      for (int i = 504; i < 512; i++) i_host.push(5'h07, 18'(i), 1'b0);
      tick();
      chk(32'(queue_full_flag), 32'h1);
      i_host.push(5'h07, 18'h3ffff, 1'b1);
      // Polled busses: one quadrant per edge, sync with quadrant one, token after four.
      n80 = 0;
      nbad = 0;
      for (int k = 0; k < 4; k++) begin
         tick();
         if (almost_full_status_bus === 8'h80) n80++;
         else if (almost_full_status_bus !== 8'h00) nbad++;
      end
      chk(32'(n80), 32'h1);
      chk(32'(nbad), 32'h0);
      n80 = 0;
      do begin
         tick();
         n80++;
      end while (almost_empty_bus_sync !== 1'b1 && n80 < 8);
      chk(32'(almost_empty_status_bus), 32'h7f);
      tick();
      chk(32'(almost_empty_status_bus), 32'hff);
      repeat (2) tick();
      chk(32'(poll_token_out), 32'h1);
      tick();
      chk(32'(almost_empty_bus_sync), 32'h1);
      // Direct mode: strobed quadrant on both busses, sync stays low.
      // Only byte lane one is written, so the queue count in lane zero must survive.
      avs_byteenable <= 4'h2;
      av_xfer(CTRL_OFS, 1'b1, 32'h0000_0100, d);
      avs_byteenable <= 4'hf;
      av_xfer(CTRL_OFS, 1'b0, '0, d);
      chk(d, 32'h0000_0120);
      i_host.strobe(5'h00);
      repeat (3) tick();
      chk(32'(almost_empty_status_bus), 32'h7f);
      chk(32'(almost_full_status_bus), 32'h80);
      chk(32'(almost_empty_bus_sync), 32'h0);
      i_host.strobe(5'h01);
      repeat (3) tick();
      chk(32'(almost_empty_status_bus), 32'hff);
      chk(32'(almost_full_status_bus), 32'h00);
      // Drain the full queue in order; the refused word must not appear.
      i_host.rd_sel(5'h07);
      for (int i = 0; i < 512; i++) begin
         wait_valid();
         chk(32'(read_data), 32'(i));
         i_host.pop();
      end
      repeat (3) tick();
      chk(32'(output_valid_flag), 32'h0);
      summarize();
   end
endmodule : multi_queue_fifo_with_flag_busses_tb_top
`default_nettype wire
